//--- hdl/i2c_front_pkg.sv
package i2c_front_pkg;
  // ==========================================
  // Address and byte layout
  localparam logic [5:0] ADDR_FIXED_BITS = 6'h20;
  localparam int BYTE_BITS = 8;
  localparam int DIR_BIT_POS = 0;
  localparam int ADDR_LOW_BIT_POS = 1;
  localparam int KIND_BIT_POS = 7;
  localparam logic [2:0] BIT_CNT_LAST = 3'h7;
  localparam logic [2:0] BIT_CNT_RESET = 3'h0;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [1:0] SYNC_RESET = 2'h3;
  localparam logic [1:0] STRAP_SYNC_RESET = 2'h0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ADDR_ACK = 3'b010,
    ST_CMD = 3'b011,
    ST_CMD_ACK = 3'b100,
    ST_IGNORE = 3'b101
  } front_state_type;
endpackage : i2c_front_pkg

//--- hdl/line_events_if.sv
`timescale 1ns/100ps
interface line_events_if;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic sda_level;
  modport producer (output scl_rise, output scl_fall, output start_seen,
                    output stop_seen, output sda_level);
  modport consumer (input scl_rise, input scl_fall, input start_seen,
                    input stop_seen, input sda_level);
endinterface : line_events_if

//--- hdl/line_sampler.sv
`timescale 1ns/100ps
module line_sampler (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  line_events_if.producer ev
);
  import i2c_front_pkg::*;

  // ==========================================
  // Two-stage synchronisers plus one history stage
  logic [1:0] scl_sync_q, scl_sync_d;
  logic [1:0] sda_sync_q, sda_sync_d;
  logic scl_prev_q, scl_prev_d;
  logic sda_prev_q, sda_prev_d;

  always_comb begin
    scl_sync_d = {scl_sync_q[0], scl_i};
    sda_sync_d = {sda_sync_q[0], sda_i};
    scl_prev_d = scl_sync_q[1];
    sda_prev_d = sda_sync_q[1];
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      scl_sync_q <= SYNC_RESET;
      sda_sync_q <= SYNC_RESET;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_sync_q <= scl_sync_d;
      sda_sync_q <= sda_sync_d;
      scl_prev_q <= scl_prev_d;
      sda_prev_q <= sda_prev_d;
    end
  end

  // Only the second stage and its history feed the detectors
  assign ev.scl_rise = scl_sync_q[1] & ~scl_prev_q;
  assign ev.scl_fall = ~scl_sync_q[1] & scl_prev_q;
  assign ev.start_seen = scl_sync_q[1] & scl_prev_q & sda_prev_q & ~sda_sync_q[1];
  assign ev.stop_seen = scl_sync_q[1] & scl_prev_q & ~sda_prev_q & sda_sync_q[1];
  assign ev.sda_level = sda_sync_q[1];
endmodule : line_sampler

//--- hdl/touch_i2c_front.sv
// How it works
// - Address is 100000 plus strap bit.
// - Strap low answers 40h, high 41h.
// - First byte: seven address bits, then direction.
// - Direction bit one reads, zero writes.
// - Matching address gets an acknowledge.
// - Stop ends transaction, wait for start.
// - Command bit seven: conversion or register.
`timescale 1ns/100ps
module touch_i2c_front (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  input wire logic addr_strap_pin,
  output logic busy_o,
  output logic read_dir_o,
  output logic [7:0] cmd_byte_o,
  output logic command_kind_bit,
  output logic cmd_valid_o,
  output logic txn_end_o
);
  import i2c_front_pkg::*;

  line_events_if ev ();

  line_sampler u_sampler (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .ev(ev)
  );

  // Strap passes two flops like any pin
  logic [1:0] strap_sync_q, strap_sync_d;
  logic addr_low_bit;

  // ==========================================
  // Matching decode
  function automatic logic addr_match(input logic [7:0] b, input logic low_bit);
    addr_match = (b[7:2] == ADDR_FIXED_BITS) && (b[ADDR_LOW_BIT_POS] == low_bit);
  endfunction : addr_match

  front_state_type state_q, state_d;
  logic [7:0] shift_q, shift_d;
  logic [2:0] bit_cnt_q, bit_cnt_d;
  logic ack_drive_q, ack_drive_d;
  logic read_dir_q, read_dir_d;
  logic [7:0] cmd_q, cmd_d;
  logic cmd_valid_q, cmd_valid_d;
  logic txn_end_q, txn_end_d;
  logic [7:0] next_byte;

  assign addr_low_bit = strap_sync_q[1];
  assign next_byte = {shift_q[6:0], ev.sda_level};

  // ==========================================
  // Strap synchroniser
  always_comb begin
    strap_sync_d = {strap_sync_q[0], addr_strap_pin};
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      strap_sync_q <= STRAP_SYNC_RESET;
    end else begin
      strap_sync_q <= strap_sync_d;
    end
  end

  // ==========================================
  // Transaction sequencer
  always_comb begin
    state_d = state_q;
    shift_d = shift_q;
    bit_cnt_d = bit_cnt_q;
    ack_drive_d = ack_drive_q;
    read_dir_d = read_dir_q;
    cmd_d = cmd_q;
    cmd_valid_d = 1'b0;
    txn_end_d = 1'b0;
    if (ev.start_seen) begin
      // Repeated start restarts address reception
      state_d = ST_ADDR;
      bit_cnt_d = BIT_CNT_RESET;
      ack_drive_d = 1'b0;
    end else if (ev.stop_seen) begin
      if (state_q != ST_IDLE) begin
        txn_end_d = 1'b1;
      end
      state_d = ST_IDLE;
      ack_drive_d = 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          ack_drive_d = 1'b0;
        end
        ST_ADDR: begin
          if (ev.scl_rise) begin
            shift_d = next_byte;
            bit_cnt_d = bit_cnt_q + 3'h1;
            if (bit_cnt_q == BIT_CNT_LAST) begin
              if (addr_match(next_byte, addr_low_bit)) begin
                read_dir_d = next_byte[DIR_BIT_POS];
                state_d = ST_ADDR_ACK;
              end else begin
                state_d = ST_IGNORE;
              end
            end
          end
        end
        ST_ADDR_ACK: begin
          // Pull data low from the falling edge after bit 8 to the next fall
          if (ev.scl_fall) begin
            if (!ack_drive_q) begin
              ack_drive_d = 1'b1;
            end else begin
              ack_drive_d = 1'b0;
              bit_cnt_d = BIT_CNT_RESET;
              // Read data phase belongs to the register logic; keep listening only
              state_d = read_dir_q ? ST_IGNORE : ST_CMD;
            end
          end
        end
        ST_CMD: begin
          if (ev.scl_rise) begin
            shift_d = next_byte;
            bit_cnt_d = bit_cnt_q + 3'h1;
            if (bit_cnt_q == BIT_CNT_LAST) begin
              cmd_d = next_byte;
              cmd_valid_d = 1'b1;
              state_d = ST_CMD_ACK;
            end
          end
        end
        ST_CMD_ACK: begin
          if (ev.scl_fall) begin
            if (!ack_drive_q) begin
              ack_drive_d = 1'b1;
            end else begin
              ack_drive_d = 1'b0;
              bit_cnt_d = BIT_CNT_RESET;
              // One command byte per transaction; later bytes go unanswered
              state_d = ST_IGNORE;
            end
          end
        end
        ST_IGNORE: begin
          ack_drive_d = 1'b0;
        end
        default: begin
          state_d = ST_IDLE;
          ack_drive_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
      shift_q <= BYTE_RESET;
      bit_cnt_q <= BIT_CNT_RESET;
      ack_drive_q <= 1'b0;
      read_dir_q <= 1'b0;
      cmd_q <= BYTE_RESET;
      cmd_valid_q <= 1'b0;
      txn_end_q <= 1'b0;
    end else begin
      state_q <= state_d;
      shift_q <= shift_d;
      bit_cnt_q <= bit_cnt_d;
      ack_drive_q <= ack_drive_d;
      read_dir_q <= read_dir_d;
      cmd_q <= cmd_d;
      cmd_valid_q <= cmd_valid_d;
      txn_end_q <= txn_end_d;
    end
  end

  // ==========================================
  // Outputs; open drain, enable low while pulling
  assign sda_o = 1'b0;
  assign sda_oe_n_o = ~ack_drive_q;
  assign busy_o = (state_q != ST_IDLE);
  assign read_dir_o = read_dir_q;
  assign cmd_byte_o = cmd_q;
  assign command_kind_bit = cmd_q[KIND_BIT_POS];
  assign cmd_valid_o = cmd_valid_q;
  assign txn_end_o = txn_end_q;
endmodule : touch_i2c_front

//--- test/i2c_host.sv
`timescale 1ns/100ps
module i2c_host (
  input wire logic sda_oe_n_i,
  output logic scl_o,
  output logic sda_o
);
  // ==========
  // Bus master, clock stands high between frames
  logic drv = 1'b1;
  initial scl_o = 1'b1;
  assign sda_o = drv & sda_oe_n_i;
  task automatic put(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      drv = b[i];
      #100 scl_o = 1'b1;
      #200 scl_o = 1'b0;
      #100;
    end
    drv = 1'b1;
    #100 scl_o = 1'b1;
    #100 ack = !sda_o; // Mid-high sample, clear of sync delay
    #100 scl_o = 1'b0;
    #100;
  endtask : put
  task automatic open_frame;
    drv = 1'b0;
    #200 scl_o = 1'b0;
    #100;
  endtask : open_frame
  task automatic restart;
    drv = 1'b1;
    #100 scl_o = 1'b1;
    #200 drv = 1'b0;
    #200 scl_o = 1'b0;
    #100;
  endtask : restart
  task automatic close_frame;
    drv = 1'b0;
    #100 scl_o = 1'b1;
    #200 drv = 1'b1;
    #1300;
  endtask : close_frame
  task automatic txn(input logic [7:0] a, input logic [7:0] c, output logic k1,
                     output logic k2);
    open_frame();
    put(a, k1);
    k2 = 1'b0;
    if (k1 && !a[0]) put(c, k2);
    close_frame();
  endtask : txn
endmodule : i2c_host

//--- test/touch_i2c_front_properties.sv
`timescale 1ns/100ps
module touch_i2c_front_properties (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_oe_n_o,
  input wire logic busy_o,
  input wire logic read_dir_o,
  input wire logic [7:0] cmd_byte_o,
  input wire logic command_kind_bit,
  input wire logic cmd_valid_o,
  input wire logic txn_end_o
);
  // ==========
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_kind; command_kind_bit == cmd_byte_o[7]; endproperty
  a_kind: assert property (p_kind) else $error("kind bit wrong");
  property p_ack; $fell(sda_oe_n_o) |-> busy_o && !sda_oe_n_o [*6]; endproperty
  a_ack: assert property (p_ack) else $error("ack short");
  property p_rel; !sda_oe_n_o |-> ##[1:12] sda_oe_n_o; endproperty
  a_rel: assert property (p_rel) else $error("ack stuck");
  property p_idle; !busy_o |-> sda_oe_n_o; endproperty
  a_idle: assert property (p_idle) else $error("drive when idle");
  property p_end; txn_end_o |-> ##[0:1] !busy_o; endproperty
  a_end: assert property (p_end) else $error("busy after stop");
  property p_dir; $changed(read_dir_o) |-> ##[0:12] !sda_oe_n_o; endproperty
  a_dir: assert property (p_dir) else $error("dir without ack");
  property p_cmd; $changed(cmd_byte_o) |-> cmd_valid_o || $past(cmd_valid_o); endproperty
  a_cmd: assert property (p_cmd) else $error("cmd without valid");
  property p_start; $rose(busy_o) |-> $past(scl_i && !sda_i); endproperty
  a_start: assert property (p_start) else $error("busy without start");
  property p_vld; cmd_valid_o |-> ##[1:12] !sda_oe_n_o; endproperty
  a_vld: assert property (p_vld) else $error("cmd not acked");
endmodule : touch_i2c_front_properties

//--- test/touch_i2c_front_tb.sv
`timescale 1ns/100ps
module touch_i2c_front_tb;
  import i2c_front_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic strap = 1'b0;
  logic scl, sda, sda_o, oe_n, busy, dir, kind, vld, tend;
  logic [7:0] cmd;
  int num_errors = 0;
  int checks_done = 0;
  int ends = 0;
  int vlds = 0;
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    ends += int'(tend === 1'b1);
    vlds += int'(vld === 1'b1);
  end
  i2c_host i2c_host_i (.sda_oe_n_i(oe_n | sda_o), .scl_o(scl), .sda_o(sda));
  touch_i2c_front touch_i2c_front_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_n_o(oe_n), .addr_strap_pin(strap), .busy_o(busy),
    .read_dir_o(dir), .cmd_byte_o(cmd), .command_kind_bit(kind), .cmd_valid_o(vld),
    .txn_end_o(tend));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  task automatic s_read;
    logic k1, k2;
    int e0;
    e0 = ends;
    strap = 1'b1;
    #400 i2c_host_i.txn({ADDR_FIXED_BITS, 1'b1, 1'b1}, 8'h00, k1, k2);
    chk(8'(k1), 8'h01);
    chk(8'(dir), 8'h01);
    chk(8'(vlds), 8'h00);
    chk(8'(sda_o), 8'h00);
    chk(8'(ends - e0), 8'h01);
  endtask : s_read
  task automatic s_match;
    logic k1, k2;
    int e0;
    int v0;
    for (int s = 0; s < 4; s++) begin
      strap = s[0];
      e0 = ends;
      v0 = vlds;
      #400 i2c_host_i.txn({ADDR_FIXED_BITS, s[0], 1'b0}, {s[1], 7'h2A}, k1, k2);
      chk(8'(k1), 8'h01);
      chk(8'(k2), 8'h01);
      chk(8'(dir), 8'h00);
      chk(cmd, {s[1], 7'h2A});
      chk(8'(kind), 8'(s[1]));
      chk(8'(busy), 8'h00);
      chk(8'(ends - e0), 8'h01);
      chk(8'(vlds - v0), 8'h01);
    end
  endtask : s_match
  task automatic s_miss;
    logic k1, k2;
    int v0;
    int e0;
    v0 = vlds;
    e0 = ends;
    strap = 1'b0;
    #400 i2c_host_i.txn({ADDR_FIXED_BITS, 1'b1, 1'b0}, 8'h11, k1, k2);
    chk(8'(k1), 8'h00);
    i2c_host_i.txn(8'hC0, 8'h11, k1, k2);
    chk(8'(k1), 8'h00);
    chk(8'(vlds - v0), 8'h00);
    chk(8'(busy), 8'h00);
    chk(8'(ends - e0), 8'h02);
  endtask : s_miss
  task automatic s_extra;
    logic k1, k2, k3;
    int v0;
    int e0;
    v0 = vlds;
    e0 = ends;
    strap = 1'b0;
    k3 = 1'b0;
    #400 i2c_host_i.open_frame();
    i2c_host_i.put({ADDR_FIXED_BITS, 1'b0, 1'b1}, k1);
    chk(8'(k1), 8'h01);
    chk(8'(dir), 8'h01);
    i2c_host_i.restart();
    i2c_host_i.put({ADDR_FIXED_BITS, 1'b0, 1'b0}, k2);
    if (k2) i2c_host_i.put(8'h93, k3);
    chk(8'(busy), 8'h01);
    i2c_host_i.close_frame();
    chk(8'(k2), 8'h01);
    chk(8'(k3), 8'h01);
    chk(cmd, 8'h93);
    chk(8'(kind), 8'h01);
    chk(8'(dir), 8'h00);
    chk(8'(vlds - v0), 8'h01);
    chk(8'(ends - e0), 8'h01);
  endtask : s_extra
  initial begin
    repeat (2) @(posedge clk_i);
    #2 rst_n_i = 1'b1;
    #400;
    s_read();
    s_match();
    s_miss();
    s_extra();
    give_verdict();
  end
endmodule : touch_i2c_front_tb
bind touch_i2c_front touch_i2c_front_properties touch_i2c_front_properties_i (
  .clk_i(clk_i),
  .rst_n_i(rst_n_i),
  .scl_i(scl_i),
  .sda_i(sda_i),
  .sda_oe_n_o(sda_oe_n_o),
  .busy_o(busy_o),
  .read_dir_o(read_dir_o),
  .cmd_byte_o(cmd_byte_o),
  .command_kind_bit(command_kind_bit),
  .cmd_valid_o(cmd_valid_o),
  .txn_end_o(txn_end_o)
);
